// File: rtl/spc_pkg.sv
// Shared constants and types for the polyphase rate converter core
package spc_pkg;
  localparam int FRAC_W = 20;
  localparam int RAM_AW = 9;
  localparam int RAM_DEPTH = 512;
  localparam int RAMP_W = 29;
  localparam int INC_W = 24;
  localparam int STEP_W = 21;
  localparam int TAP_W = 10;
  localparam int WIN_W = 6;
  localparam int SMP_W = 24;
  localparam int COEF_W = 18;
  localparam int ACC_W = 52;
  localparam int ROM_PW = 26;
  localparam int GAIN_SHIFT = 21;
  localparam int KP_FAST = 1;
  localparam int KI_FAST = 4;
  localparam int KP_SLOW = 3;
  localparam int KI_SLOW = 9;
  localparam int MUTE_BIT = 7;
  localparam int CLK_SOURCE_LSB = 0;
  localparam int CLK_DIV_LSB = 2;
  localparam logic [7:0] CLK_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
  localparam logic [RAM_AW-1:0] WR_OFFSET_BASE = 9'h010;
  localparam logic [TAP_W-1:0] TAPS_BASE = 10'h040;
  localparam logic [TAP_W-1:0] TAPS_MAX = 10'h1c0;
  localparam logic [TAP_W-1:0] TAP_SAT = 10'h3ff;
  localparam logic [TAP_W-1:0] RATIO_HYST = 10'h002;
  localparam logic [WIN_W-1:0] WIN_LAST = 6'h3f;
  localparam logic [STEP_W-1:0] STEP_UNITY = 21'h10_0000;
  localparam logic [ROM_PW-1:0] ROM_UNITY = 26'h010_0000;
  localparam logic [26:0] DIV_NUM = 27'h400_0000;
  localparam logic [4:0] DIV_STEPS = 5'h1b;
  localparam logic [INC_W-1:0] INC_INIT = 24'h10_0000;
  localparam logic [RAMP_W-1:0] SETTLE_TH = 29'h0004_0000;
  localparam logic [3:0] SETTLE_LAST = 4'h7;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LEFT  = 4'b0010,
    ST_RIGHT = 4'b0100,
    ST_DONE  = 4'b1000
  } spc_conv_e;
endpackage

// File: rtl/spc_mac_if.sv
// Request and result bundle of the shared multiply-accumulate
`timescale 1ns/1ps
interface spc_mac_if;
  import spc_pkg::*;
  logic                    clear;
  logic                    op;
  logic                    chan;
  logic signed [SMP_W-1:0] smp;
  logic signed [COEF_W-1:0] coef;
  logic signed [ACC_W-1:0] acc_l;
  logic signed [ACC_W-1:0] acc_r;
  modport ctrl (output clear, op, chan, smp, coef, input acc_l, acc_r);
  modport mac  (input clear, op, chan, smp, coef, output acc_l, acc_r);
endinterface

// File: rtl/spc_mac.sv
// Multiply-accumulate unit shared by left and right channels
`timescale 1ns/1ps
module spc_mac
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  // Operand and result bundle
  spc_mac_if.mac    mac_if
);
  logic signed [SMP_W+COEF_W-1:0] prod;
  logic signed [ACC_W-1:0]        prod_x;

  assign prod   = mac_if.smp * mac_if.coef;
  assign prod_x = ACC_W'(prod);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mac_if.acc_l <= '0;
      mac_if.acc_r <= '0;
    end else if (mac_if.clear) begin
      mac_if.acc_l <= '0;
      mac_if.acc_r <= '0;
    end else if (mac_if.op && mac_if.chan) begin
      mac_if.acc_r <= mac_if.acc_r + prod_x;
    end else if (mac_if.op) begin
      mac_if.acc_l <= mac_if.acc_l + prod_x;
    end
  end
endmodule // spc_mac

// File: rtl/spc_rate_ratio.sv
// Input to output rate ratio measurement with hysteresis
`timescale 1ns/1ps
module spc_rate_ratio
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  // Rate ticks
  input  wire logic             in_tick_in,
  input  wire logic             out_tick_in,
  // Ratio results
  output logic [STEP_W-1:0]     step_out,
  output logic [TAP_W-1:0]      taps_out,
  output logic                  decim_out,
  output logic                  changed_out
);
  logic [WIN_W-1:0] win_cnt;
  logic [TAP_W-1:0] in_cnt;
  logic [TAP_W-1:0] n_prev;
  logic [TAP_W-1:0] n_diff;
  logic             win_end;
  logic             div_go;
  logic             div_busy;
  logic             div_fin;
  logic [4:0]       div_cnt;
  logic [26:0]      num;
  logic [26:0]      quo;
  logic [TAP_W-1:0] rem;
  logic [TAP_W:0]   trial;
  logic             fit;

  assign win_end = out_tick_in && (win_cnt == WIN_LAST);
  assign n_diff  = (in_cnt > n_prev) ? in_cnt - n_prev : n_prev - in_cnt;
  assign trial   = {rem, num[26]};
  assign fit     = trial >= {1'b0, taps_out};

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      win_cnt <= '0;
      in_cnt  <= '0;
    end else begin
      if (out_tick_in)
        win_cnt <= win_cnt + 1'b1;
      if (win_end)
        in_cnt <= {{(TAP_W-1){1'b0}}, in_tick_in};
      else if (in_tick_in && in_cnt != TAP_SAT)
        in_cnt <= in_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      decim_out   <= 1'b0;
      taps_out    <= TAPS_BASE;
      step_out    <= STEP_UNITY;
      n_prev      <= '0;
      changed_out <= 1'b0;
      div_go      <= 1'b0;
    end else begin
      changed_out <= 1'b0;
      div_go      <= 1'b0;
      if (win_end && in_cnt <= TAPS_BASE && decim_out) begin
        decim_out   <= 1'b0;
        taps_out    <= TAPS_BASE;
        step_out    <= STEP_UNITY;
        changed_out <= 1'b1;
      end else if (win_end && in_cnt > TAPS_BASE && (!decim_out || n_diff > RATIO_HYST)) begin
        decim_out   <= 1'b1;
        n_prev      <= in_cnt;
        taps_out    <= (in_cnt > TAPS_MAX) ? TAPS_MAX : in_cnt;
        div_go      <= 1'b1;
        changed_out <= 1'b1;
      end else if (div_fin) begin
        step_out <= quo[STEP_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_busy <= 1'b0;
      div_fin  <= 1'b0;
      div_cnt  <= '0;
      num      <= '0;
      quo      <= '0;
      rem      <= '0;
    end else begin
      div_fin <= 1'b0;
      if (div_go) begin
        div_busy <= 1'b1;
        div_cnt  <= DIV_STEPS;
        num      <= DIV_NUM;
        quo      <= '0;
        rem      <= '0;
      end else if (div_busy) begin
        num     <= {num[25:0], 1'b0};
        quo     <= {quo[25:0], fit};
        rem     <= fit ? TAP_W'(trial - {1'b0, taps_out}) : trial[TAP_W-1:0];
        div_cnt <= div_cnt - 1'b1;
        if (div_cnt == 5'h01) begin
          div_busy <= 1'b0;
          div_fin  <= 1'b1;
        end
      end
    end
  end
endmodule // spc_rate_ratio

// File: rtl/spc_polyphase_convolver.sv
// Rate converter core: servo loop, polyphase convolution and control
`timescale 1ns/1ps
module spc_polyphase_convolver
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  // Register port
  input  wire logic             reg_wr_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [7:0]       reg_wdata_in,
  output logic      [7:0]       reg_rdata_out,
  // Control and status
  input  wire logic [7:0]       group_delay_mute_in,
  input  wire logic             slow_irq_en_in,
  output logic                  fast_mode_mute_flag_out,
  output logic                  slow_mode_irq_out,
  output logic      [1:0]       clk_source_sel_out,
  output logic      [1:0]       clk_div_sel_out,
  // Input samples
  input  wire logic             in_valid_in,
  input  wire logic [SMP_W-1:0] in_left_in,
  input  wire logic [SMP_W-1:0] in_right_in,
  // Output samples
  input  wire logic             out_tick_in,
  output logic                  out_valid_out,
  output logic      [SMP_W-1:0] out_left_out,
  output logic      [SMP_W-1:0] out_right_out
);
  logic [7:0]               clk_ctrl;
  logic [SMP_W-1:0]         ram_l [RAM_DEPTH];
  logic [SMP_W-1:0]         ram_r [RAM_DEPTH];
  logic [RAM_AW-1:0]        in_count;
  logic [RAM_AW-1:0]        wr_addr;
  logic [RAMP_W-1:0]        ramp;
  logic [RAM_AW-1:0]        ramp_int;
  logic [INC_W-1:0]         inc_est;
  logic signed [RAMP_W-1:0] err;
  logic signed [RAMP_W-1:0] p_term;
  logic signed [RAMP_W-1:0] i_term;
  logic [RAMP_W-1:0]        err_mag;
  logic                     settled;
  logic [3:0]               settle_cnt;
  logic                     fast;
  logic [STEP_W-1:0]        step;
  logic [TAP_W-1:0]         taps;
  logic                     decim;
  logic                     rate_chg;
  logic [FRAC_W+STEP_W-1:0] frac_prod;
  logic [ROM_PW-1:0]        rom_start;
  spc_conv_e                state;
  logic                     start;
  logic [RAM_AW-1:0]        rd_ptr;
  logic [ROM_PW-1:0]        rom_ptr;
  logic [ROM_PW:0]          next_rom;
  logic [TAP_W-1:0]         tap_cnt;
  logic                     conv_end;
  logic [15:0]              tri_c;
  logic [15+STEP_W:0]       coef_prod;
  logic [15:0]              coef_mag;
  logic                     soft_mute;

  spc_mac_if mac_if ();

  // Register port and clock selection

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      clk_ctrl <= CLK_CTRL_RESET;
    else if (reg_wr_in && reg_addr_in == CLK_CTRL_ADDR)
      clk_ctrl <= reg_wdata_in;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      reg_rdata_out <= 8'h00;
    else if (reg_addr_in == CLK_CTRL_ADDR)
      reg_rdata_out <= clk_ctrl;
    else
      reg_rdata_out <= 8'h00;
  end

  assign clk_source_sel_out = clk_ctrl[CLK_SOURCE_LSB +: 2];
  assign clk_div_sel_out    = clk_ctrl[CLK_DIV_LSB +: 2];
  assign soft_mute          = group_delay_mute_in[MUTE_BIT];

  // Sample memory and input counter

  assign wr_addr = in_count + WR_OFFSET_BASE + {2'b00, group_delay_mute_in[6:0]};

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      in_count <= '0;
    else if (in_valid_in)
      in_count <= in_count + 1'b1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (in_valid_in) begin
      ram_l[wr_addr] <= in_left_in;
      ram_r[wr_addr] <= in_right_in;
    end
  end

  // Rate ratio measurement

  spc_rate_ratio u_ratio (
    .ref_clk_in  (ref_clk_in),
    .arst_n_in   (arst_n_in),
    .in_tick_in  (in_valid_in),
    .out_tick_in (out_tick_in),
    .step_out    (step),
    .taps_out    (taps),
    .decim_out   (decim),
    .changed_out (rate_chg)
  );

  // Digital servo loop

  assign err     = signed'({in_count, {FRAC_W{1'b0}}} - ramp);
  assign p_term  = fast ? (err >>> KP_FAST) : (err >>> KP_SLOW);
  assign i_term  = fast ? (err >>> KI_FAST) : (err >>> KI_SLOW);
  assign err_mag = err[RAMP_W-1] ? RAMP_W'(-err) : RAMP_W'(err);
  assign settled = err_mag < SETTLE_TH;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ramp    <= '0;
      inc_est <= INC_INIT;
    end else if (out_tick_in) begin
      ramp    <= ramp + RAMP_W'(inc_est) + RAMP_W'(p_term);
      inc_est <= inc_est + INC_W'(i_term);
    end
  end

  assign ramp_int = ramp[RAMP_W-1:FRAC_W];

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      settle_cnt <= '0;
    else if (rate_chg)
      settle_cnt <= '0;
    else if (out_tick_in && !settled)
      settle_cnt <= '0;
    else if (out_tick_in && settle_cnt != SETTLE_LAST)
      settle_cnt <= settle_cnt + 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fast              <= 1'b1;
      slow_mode_irq_out <= 1'b0;
    end else begin
      slow_mode_irq_out <= 1'b0;
      if (rate_chg) begin
        fast <= 1'b1;
      end else if (fast && out_tick_in && settled && settle_cnt == SETTLE_LAST) begin
        fast <= 1'b0;
        slow_mode_irq_out <= slow_irq_en_in;
      end
    end
  end

  assign fast_mode_mute_flag_out = fast;

  // Coefficient generation

  assign frac_prod = ramp[FRAC_W-1:0] * step;
  assign rom_start = decim ? ROM_PW'(frac_prod[FRAC_W+STEP_W-2:FRAC_W])
                           : ROM_PW'(ramp[FRAC_W-1:0]);

  assign tri_c = rom_ptr[ROM_PW-1] ? ~rom_ptr[ROM_PW-2:ROM_PW-17]
                                   : rom_ptr[ROM_PW-2:ROM_PW-17];
  assign coef_prod = tri_c * step;

  assign coef_mag = decim ? coef_prod[FRAC_W+15:FRAC_W] : tri_c;

  // Convolution sequencing

  assign start    = (state == ST_IDLE) && out_tick_in;
  assign next_rom = {1'b0, rom_ptr} + {{(ROM_PW+1-STEP_W){1'b0}}, step};

  assign conv_end = next_rom[ROM_PW] || (tap_cnt == taps - 1'b1);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state   <= ST_IDLE;
      rd_ptr  <= '0;
      rom_ptr <= '0;
      tap_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (out_tick_in) begin
            rd_ptr  <= ramp_int;
            rom_ptr <= rom_start;
            tap_cnt <= '0;
            state   <= ST_LEFT;
          end
        end
        ST_LEFT: begin
          state <= ST_RIGHT;
        end
        ST_RIGHT: begin
          rd_ptr  <= rd_ptr - 1'b1;
          rom_ptr <= next_rom[ROM_PW-1:0];
          tap_cnt <= tap_cnt + 1'b1;
          state   <= conv_end ? ST_DONE : ST_LEFT;
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign mac_if.clear = start;
  assign mac_if.op    = (state == ST_LEFT) || (state == ST_RIGHT);
  assign mac_if.chan  = (state == ST_RIGHT);
  assign mac_if.smp   = mac_if.chan ? ram_r[rd_ptr] : ram_l[rd_ptr];
  assign mac_if.coef  = {2'b00, coef_mag};

  spc_mac u_mac (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .mac_if     (mac_if)
  );

  // Output samples

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_valid_out <= 1'b0;
      out_left_out  <= '0;
      out_right_out <= '0;
    end else begin
      out_valid_out <= (state == ST_DONE);
      if (state == ST_DONE && soft_mute) begin
        out_left_out  <= '0;
        out_right_out <= '0;
      end else if (state == ST_DONE) begin
        out_left_out  <= mac_if.acc_l[GAIN_SHIFT+SMP_W-1:GAIN_SHIFT];
        out_right_out <= mac_if.acc_r[GAIN_SHIFT+SMP_W-1:GAIN_SHIFT];
      end
    end
  end

  // Checks

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence tap_pair_s;
    (state == ST_LEFT) ##1 (state == ST_RIGHT);
  endsequence

  sequence finish_s;
    (state == ST_DONE) ##1 out_valid_out;
  endsequence

  property conv_start_p;
    start |=> tap_pair_s;
  endproperty

  property wrap_finish_p;
    (state == ST_RIGHT) && next_rom[ROM_PW] |=> finish_s;
  endproperty

  fast_entry_a: assert property (rate_chg |=> fast_mode_mute_flag_out)
    else $error("Rate change did not enter fast mode");

  slow_exit_a: assert property (
    $fell(fast_mode_mute_flag_out) |-> $past(settled) && $past(settle_cnt) == SETTLE_LAST)
    else $error("Fast mode left before settling");

  flag_hold_a: assert property (
    fast_mode_mute_flag_out && !(out_tick_in && settled) |=> fast_mode_mute_flag_out)
    else $error("Mute flag dropped while still in fast mode");

  irq_raise_a: assert property (
    $fell(fast_mode_mute_flag_out) && $past(slow_irq_en_in) |-> slow_mode_irq_out)
    else $error("No interrupt on entry to slow mode");

  irq_cause_a: assert property (
    slow_mode_irq_out |-> $fell(fast_mode_mute_flag_out) && $past(slow_irq_en_in))
    else $error("Interrupt without slow mode entry");

  mute_out_a: assert property (
    out_valid_out && $past(soft_mute) |-> out_left_out == '0 && out_right_out == '0)
    else $error("Soft mute let audio through");

  tap_len_a: assert property (
    (state == ST_RIGHT) && !decim |-> tap_cnt < TAPS_BASE)
    else $error("Unity convolution ran past its tap count");

  load_ptr_a: assert property (start |=> rd_ptr == $past(ramp_int))
    else $error("RAM start pointer not loaded from servo");

  ram_dec_a: assert property (
    (state == ST_RIGHT) |=> rd_ptr == $past(rd_ptr) - 1'b1)
    else $error("Sample address did not step down by one");

  rom_step_a: assert property (
    (state == ST_RIGHT) && !decim && !conv_end |=> rom_ptr == $past(rom_ptr) + ROM_UNITY)
    else $error("Coefficient pointer step wrong at unity ratio");

  wrap_end_a: assert property (wrap_finish_p)
    else $error("Pointer rollover did not end the convolution");

  mac_share_a: assert property (conv_start_p)
    else $error("Tap not issued left then right on the shared unit");

  unity_step_a: assert property (
    !decim |-> step == STEP_UNITY && taps == TAPS_BASE)
    else $error("Ratio not unity while not decimating");

endmodule // spc_polyphase_convolver

// File: tb/spc_audio_port.sv
// Behavioural audio source and sink around the rate converter core
`timescale 1ns/1ps
module spc_audio_port
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  // Rate control
  input  wire logic [15:0]      in_period_in,
  input  wire logic [15:0]      out_period_in,
  // Source side
  output logic                  in_valid_out,
  output logic      [SMP_W-1:0] in_left_out,
  output logic      [SMP_W-1:0] in_right_out,
  output logic                  out_tick_out,
  // Sink side
  input  wire logic             out_valid_in,
  output logic      [15:0]      latency_out,
  output logic      [15:0]      out_count_out
);
  logic [15:0]      in_cnt;
  logic [15:0]      tick_cnt;
  logic [15:0]      tick_age;
  logic [SMP_W-1:0] phase;

  always @(negedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      in_cnt       <= 16'h0000;
      tick_cnt     <= 16'h0000;
      phase        <= 24'h00_0000;
      in_valid_out <= 1'b0;
      out_tick_out <= 1'b0;
      in_left_out  <= 24'h00_0000;
      in_right_out <= 24'hff_ffff;
    end else begin
      in_cnt       <= (in_cnt + 16'h0001 >= in_period_in) ? 16'h0000 : in_cnt + 16'h0001;
      tick_cnt     <= (tick_cnt + 16'h0001 >= out_period_in) ? 16'h0000 : tick_cnt + 16'h0001;
      in_valid_out <= (in_cnt == 16'h0000);
      out_tick_out <= (tick_cnt == 16'h0000);
      // Lines toggle away from the strobe
      if (in_cnt == 16'h0000) begin
        phase        <= phase + 24'h01_2345;
        in_left_out  <= phase;
        in_right_out <= ~phase;
      end else begin
        in_left_out  <= ~in_left_out;
        in_right_out <= ~in_right_out;
      end
    end
  end

  // Cycles from tick edge to result pulse
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_age      <= 16'h0000;
      latency_out   <= 16'h0000;
      out_count_out <= 16'h0000;
    end else begin
      // Tick edge counts as one so the result edge reads the full span
      tick_age <= out_tick_out ? 16'h0001 : tick_age + 16'h0001;
      if (out_valid_in) begin
        latency_out   <= tick_age;
        out_count_out <= out_count_out + 16'h0001;
      end
    end
  end
endmodule // spc_audio_port

// File: tb/tb_spc_polyphase_convolver.sv
// Self-checking bench of the rate converter core
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[FAIL] %0t %s", $time, msg); \
    end \
  end
module tb_spc_polyphase_convolver;
  import spc_pkg::*;
  logic             ref_clk;
  logic             arst_n;
  logic             reg_wr;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic [7:0]       reg_rdata;
  logic [7:0]       gd_mute;
  logic             irq_en;
  logic             flag;
  logic             irq;
  logic [1:0]       src_sel;
  logic [1:0]       div_sel;
  logic             in_valid;
  logic [SMP_W-1:0] in_left;
  logic [SMP_W-1:0] in_right;
  logic             out_tick;
  logic             out_valid;
  logic [SMP_W-1:0] out_left;
  logic [SMP_W-1:0] out_right;
  logic [15:0]      in_period;
  logic [15:0]      out_period;
  logic [15:0]      latency;
  logic [15:0]      out_count;
  int               bad_count;
  int               cmp_count;

  spc_polyphase_convolver DUT (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .reg_wr_in(reg_wr), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .group_delay_mute_in(gd_mute),
    .slow_irq_en_in(irq_en), .fast_mode_mute_flag_out(flag), .slow_mode_irq_out(irq),
    .clk_source_sel_out(src_sel), .clk_div_sel_out(div_sel), .in_valid_in(in_valid),
    .in_left_in(in_left), .in_right_in(in_right), .out_tick_in(out_tick),
    .out_valid_out(out_valid), .out_left_out(out_left), .out_right_out(out_right));

  spc_audio_port port (
    .ref_clk_in(ref_clk), .arst_n_in(arst_n), .in_period_in(in_period),
    .out_period_in(out_period), .in_valid_out(in_valid), .in_left_out(in_left),
    .in_right_out(in_right), .out_tick_out(out_tick), .out_valid_in(out_valid),
    .latency_out(latency), .out_count_out(out_count));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic wait_outs(input int n);
    logic [15:0] c0;
    int          i;
    repeat (n) begin
      c0 = out_count;
      i  = 0;
      while (out_count === c0 && i < 2000) begin
        @(negedge ref_clk);
        i++;
      end
    end
  endtask

  task automatic wait_flag(input logic lvl, input int limit);
    int i;
    i = 0;
    while (flag !== lvl && i < limit) begin
      @(negedge ref_clk);
      i++;
    end
  endtask

  task automatic t_regs();
    reg_write(CLK_CTRL_ADDR, 8'ha6);
    `CHK(src_sel, 2'b10, "clock source select")
    `CHK(div_sel, 2'b01, "clock divider select")
    repeat (2) @(negedge ref_clk);
    `CHK(reg_rdata, 8'ha6, "clock control readback")
    reg_write(8'h01, 8'h5f);
    repeat (2) @(negedge ref_clk);
    `CHK(reg_rdata, 8'h00, "unmapped read")
    `CHK(src_sel, 2'b10, "unmapped write ignored")
    reg_addr = CLK_CTRL_ADDR;
    repeat (2) @(negedge ref_clk);
    `CHK(reg_rdata, 8'ha6, "readback after unmapped")
  endtask

  task automatic t_unity();
    wait_outs(2);
    `CHK(latency, 16'd130, "unity convolution length")
    wait_flag(1'b0, 40000);
    `CHK(flag, 1'b0, "slow mode reached")
    `CHK(irq, 1'b1, "slow mode interrupt")
    @(negedge ref_clk);
    `CHK(irq, 1'b0, "interrupt single cycle")
  endtask

  task automatic t_mute();
    gd_mute = 8'h85;
    wait_outs(2);
    `CHK(out_left, 24'h00_0000, "muted left")
    `CHK(out_right, 24'h00_0000, "muted right")
    gd_mute = 8'h05;
    wait_outs(1);
  endtask

  task automatic t_decim();
    out_period = 16'd270;
    in_period  = 16'd135;
    wait_flag(1'b1, 45000);
    `CHK(flag, 1'b1, "fast mode on rate change")
    wait_outs(70);
    `CHK(latency, 16'd258, "decimating convolution length")
  endtask

  task automatic t_hyst();
    in_period = 16'd133;
    wait_outs(140);
    `CHK(latency, 16'd258, "small ratio change held")
  endtask

  initial begin
    arst_n     = 1'b0;
    reg_wr     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    gd_mute    = 8'h00;
    irq_en     = 1'b1;
    in_period  = 16'h0100;
    out_period = 16'h0100;
    bad_count  = 0;
    cmp_count  = 0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(flag, 1'b1, "fast mode at startup")
    `CHK(irq, 1'b0, "no interrupt in reset")
    `CHK(reg_rdata, CLK_CTRL_RESET, "clock control reset")
    arst_n = 1'b1;
    t_regs();
    t_unity();
    t_mute();
    t_decim();
    t_hyst();
    summarize();
  end

  initial begin
    repeat (95000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
endmodule // tb_spc_polyphase_convolver
